// *** design/ccd_readout_seq.sv ***
`timescale 1ns/10ps
module ccd_readout_seq #(
   parameter logic [ccd_seq_pkg::CNT_W-1:0] N_LINES  = ccd_seq_pkg::LINES_DEF,
   parameter logic [ccd_seq_pkg::CNT_W-1:0] N_PIXELS = ccd_seq_pkg::PIXELS_DEF
) (
   input  wire logic                          clk_i,
   input  wire logic                          rstn_i,
   input  wire logic                          start_i,
   input  wire logic                          run_i,
   input  wire logic                          shutter_en_i,
   input  wire logic                          dual_reg_i,
   input  wire logic [ccd_seq_pkg::US_W-1:0]   integ_us_i,
   input  wire logic [ccd_seq_pkg::DATA_W-1:0] adc_data_i,
   input  wire logic                          pix_ready_i,
   output logic                               vertical_phase_one_o,
   output logic                               vertical_phase_two_o,
   output logic                               pd_xfer_o,
   output logic                               horiz_reg_a_phase_one_o,
   output logic                               horiz_reg_b_phase_one_o,
   output logic                               horiz_phase_two_o,
   output logic                               reg_ab_xfer_o,
   output logic                               reset_gate_o,
   output logic                               clamp_o,
   output logic                               sample_o,
   output logic                               substrate_shutter_o,
   output logic                               fast_line_dump_gate_o,
   output logic                               busy_o,
   output logic                               pix_valid_o,
   output logic [ccd_seq_pkg::DATA_W-1:0]      pix_data_o,
   output logic                               pix_last_o
);
   import ccd_seq_pkg::*;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function automatic logic [TCNT_W-1:0] dur(input state_t s);
      case (s)
         ST_ES_GAP:  dur = ES_GAP_CYC;
         ST_SHUTTER: dur = SHUTTER_CYC;
         ST_XFER:    dur = XFER_CYC;
         ST_RDELAY:  dur = RD_DELAY_CYC;
         ST_V1:      dur = VPULSE_CYC;
         ST_V2:      dur = VPULSE_CYC;
         ST_AB:      dur = AB_CYC;
         ST_HDELAY:  dur = HDELAY_CYC;
         ST_VDELAY:  dur = VDELAY_CYC;
         default:    dur = 12'h001;
      endcase
   endfunction

   // Without a shutter the frame goes straight to transfer, so the whole frame integrates.
   function automatic state_t first_state(input logic shut);
      first_state = shut ? ST_ES_GAP : ST_XFER;
   endfunction

   state_t              state_q;
   state_t              state_d;
   logic [TCNT_W-1:0]   timer_q;
   logic [4:0]          div_q;
   logic [US_W-1:0]     integ_cnt_q;
   logic [US_W-1:0]     integ_tgt_q;
   logic                dual_q;
   logic [CNT_W-1:0]    line_q;
   logic [CNT_W-1:0]    pix_q;
   logic [1:0]          ph_q;
   logic                t_done;
   logic                us_tick;
   logic                integ_done;
   logic                last_line;
   logic                last_pix;
   logic                buf_ready;
   logic                push;
   logic                frame_start;
   logic [DATA_W:0]     buf_out;

   assign t_done = (timer_q == '0);
   assign us_tick = (div_q == US_CYC - 5'h01);
   assign integ_done = us_tick && (integ_cnt_q == integ_tgt_q - 16'h0001);
   assign last_line = (line_q == N_LINES - 10'h001);
   assign last_pix = (pix_q == N_PIXELS - 10'h001);
   assign push = (state_q == ST_PIXEL) && (ph_q == PH_SAMPLE) && buf_ready;
   // Only leaving idle or the last line's end starts a frame; the end of any other line must not retake modes.
   assign frame_start = (state_q != state_d)
                        && (state_q == ST_IDLE || (state_q == ST_VDELAY && last_line));

   // ***************************************************************
   // Frame, line and pixel sequencing
   // ***************************************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (start_i) state_d = first_state(shutter_en_i);
         ST_ES_GAP: if (t_done) state_d = ST_SHUTTER;
         ST_SHUTTER: if (t_done) state_d = ST_INTEG;
         ST_INTEG: if (integ_done) state_d = ST_XFER;
         ST_XFER: if (t_done) state_d = ST_RDELAY;
         ST_RDELAY: if (t_done) state_d = ST_V1;
         ST_V1: if (t_done) state_d = ST_V2;
         ST_V2: if (t_done) state_d = dual_q ? ST_AB : ST_HDELAY;
         ST_AB: if (t_done) state_d = ST_HDELAY;
         ST_HDELAY: if (t_done) state_d = ST_PIXEL;
         ST_PIXEL: if (push && last_pix) state_d = ST_VDELAY;
         ST_VDELAY: begin
            if (t_done) begin
               if (!last_line) state_d = ST_V1;
               else if (run_i) state_d = first_state(shutter_en_i);
               else state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) state_q <= ST_IDLE;
      else state_q <= state_d;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) timer_q <= '0;
      else if (state_d != state_q) timer_q <= dur(state_d) - 12'h001;
      else if (!t_done) timer_q <= timer_q - 12'h001;
   end

   // Modes are taken only at frame start; a change mid-frame would tear the image.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dual_q <= 1'b0;
         integ_tgt_q <= INTEG_MIN_US;
      end else if (frame_start) begin
         dual_q <= dual_reg_i;
         integ_tgt_q <= (integ_us_i < INTEG_MIN_US) ? INTEG_MIN_US : integ_us_i;
      end
   end

   // The microsecond divider restarts on entry so the wait is exact, not off by a tick.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_q <= '0;
         integ_cnt_q <= '0;
      end else if (state_q != ST_INTEG) begin
         div_q <= '0;
         integ_cnt_q <= '0;
      end else if (us_tick) begin
         div_q <= '0;
         integ_cnt_q <= integ_cnt_q + 16'h0001;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) line_q <= '0;
      else if (state_q == ST_XFER) line_q <= '0;
      else if (state_q == ST_VDELAY && t_done) line_q <= line_q + 10'h001;
   end

   // A stalled receiver freezes the pixel in its sample phase, stretching the clock.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ph_q <= PH_RESET;
         pix_q <= '0;
      end else if (state_q != ST_PIXEL) begin
         ph_q <= PH_RESET;
         pix_q <= '0;
      end else if (ph_q != PH_SAMPLE || push) begin
         ph_q <= ph_q + 2'h1;
         if (push) pix_q <= pix_q + 10'h001;
      end
   end

   // ***************************************************************
   // Pin drivers
   // ***************************************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         vertical_phase_one_o <= 1'b0;
         vertical_phase_two_o <= 1'b0;
         pd_xfer_o <= 1'b0;
         horiz_reg_a_phase_one_o <= 1'b0;
         horiz_reg_b_phase_one_o <= 1'b0;
         horiz_phase_two_o <= 1'b0;
         reg_ab_xfer_o <= 1'b0;
         reset_gate_o <= 1'b0;
         clamp_o <= 1'b0;
         sample_o <= 1'b0;
         substrate_shutter_o <= 1'b0;
         fast_line_dump_gate_o <= FDG_DISABLE;
         busy_o <= 1'b0;
      end else begin
         vertical_phase_one_o <= (state_q == ST_V1);
         vertical_phase_two_o <= (state_q == ST_V2);
         pd_xfer_o <= (state_q == ST_XFER);
         horiz_reg_a_phase_one_o <= (state_q == ST_PIXEL) && !ph_q[1];
         horiz_reg_b_phase_one_o <= dual_q && (state_q == ST_PIXEL) && !ph_q[1];
         horiz_phase_two_o <= (state_q == ST_PIXEL) && ph_q[1];
         reg_ab_xfer_o <= (state_q == ST_AB);
         reset_gate_o <= (state_q == ST_PIXEL) && (ph_q == PH_RESET);
         clamp_o <= (state_q == ST_PIXEL) && (ph_q == PH_CLAMP);
         sample_o <= (state_q == ST_PIXEL) && (ph_q == PH_SAMPLE);
         substrate_shutter_o <= (state_q == ST_SHUTTER);
         fast_line_dump_gate_o <= FDG_DISABLE;
         busy_o <= (state_q != ST_IDLE);
      end
   end

   pix_skid_buf pix_skid_buf_inst (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (push),
      .in_data_i   ({last_pix, adc_data_i}),
      .in_ready_o  (buf_ready),
      .out_valid_o (pix_valid_o),
      .out_data_o  (buf_out),
      .out_ready_i (pix_ready_i)
   );

   assign pix_data_o = buf_out[DATA_W-1:0];
   assign pix_last_o = buf_out[DATA_W];

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   logic [4:0]         pv;
   logic [TCNT_W-1:0]  len_q [5];
   logic [US_W-1:0]    since_shut_q;
   logic [US_W-1:0]    since_xfer_q;
   logic [US_W-1:0]    since_h_q;
   logic               shut_seen_q;

   assign pv = {reg_ab_xfer_o, vertical_phase_two_o, vertical_phase_one_o,
                pd_xfer_o, substrate_shutter_o};

   for (genvar i = 0; i < 5; i++) begin : g_len
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) len_q[i] <= '0;
         else if (!pv[i]) len_q[i] <= '0;
         else if (len_q[i] != '1) len_q[i] <= len_q[i] + 12'h001;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         since_shut_q <= '0;
         since_xfer_q <= '1;
         since_h_q <= '1;
         shut_seen_q <= 1'b0;
      end else begin
         since_shut_q <= substrate_shutter_o ? '0 :
                         (since_shut_q == '1 ? since_shut_q : since_shut_q + 16'h0001);
         since_xfer_q <= pd_xfer_o ? '0 :
                         (since_xfer_q == '1 ? since_xfer_q : since_xfer_q + 16'h0001);
         since_h_q <= (horiz_reg_a_phase_one_o || horiz_phase_two_o) ? '0 :
                      (since_h_q == '1 ? since_h_q : since_h_q + 16'h0001);
         if (substrate_shutter_o) shut_seen_q <= 1'b1;
         else if (pd_xfer_o) shut_seen_q <= 1'b0;
      end
   end

   a_shutter_width: assert property ($fell(substrate_shutter_o) |-> len_q[0] == SHUTTER_CYC)
      else $error("shutter pulse width wrong");
   a_integ_min_time: assert property ($rose(pd_xfer_o) && shut_seen_q
                                      |-> since_shut_q >= INTEG_MIN_CYC)
      else $error("integration shorter than minimum");
   a_xfer_width: assert property ($fell(pd_xfer_o) |-> len_q[1] == XFER_CYC)
      else $error("transfer pulse width wrong");
   a_vphase_one_width: assert property ($fell(vertical_phase_one_o) |-> len_q[2] == VPULSE_CYC)
      else $error("vertical phase one width wrong");
   a_vphase_two_width: assert property ($fell(vertical_phase_two_o) |-> len_q[3] == VPULSE_CYC)
      else $error("vertical phase two width wrong");
   a_ab_xfer_width: assert property ($fell(reg_ab_xfer_o) |-> len_q[4] == AB_CYC)
      else $error("register transfer width wrong");
   a_shutter_h_gap: assert property ($rose(substrate_shutter_o) |-> since_h_q >= ES_GAP_CYC)
      else $error("horizontal clocking too close to shutter");
   a_single_reg_b: assert property (horiz_reg_b_phase_one_o |-> $past(dual_q))
      else $error("register B toggled in single mode");
   a_dump_gate_static: assert property ($stable(fast_line_dump_gate_o)
                                        && fast_line_dump_gate_o == FDG_DISABLE)
      else $error("fast dump gate moved");
   a_pixel_order: assert property (reset_gate_o |=> clamp_o ##1 (!clamp_o && !sample_o)
                                   ##1 sample_o)
      else $error("pixel strobe order wrong");
   a_read_delay_min: assert property ($rose(vertical_phase_one_o)
                                      |-> since_xfer_q >= RD_DELAY_CYC)
      else $error("line shift too soon after transfer");

   c_shutter_frame: cover property ($rose(pd_xfer_o) && shut_seen_q);
   c_dual_line: cover property ($fell(reg_ab_xfer_o) ##[1:100] horiz_reg_b_phase_one_o);
   c_rx_stall: cover property ((pix_valid_o && !pix_ready_i) [*3]);
   c_last_pixel: cover property (pix_valid_o && pix_ready_i && pix_last_o);

endmodule

// *** design/ccd_seq_pkg.sv ***
// Functional notes
// - Shutter pulse on the substrate lasts at least 10 us; nominal 25 us.
// - Integration from shutter end to photodiode transfer is never below 0.1 ms.
// - Photodiode-to-vertical transfer pulse lasts at least 4 us; nominal 5 us.
// - Each vertical phase pulse of a line shift lasts at least 2 us; nominal 2.5 us.
// - Dual mode register A to B transfer pulse lasts at least 2 us; nominal 2.5 us.
// - Keep at least 1 us between shutter pulse and horizontal clocking.
// - Single register mode holds register B phase one low, never toggled.
// - Without shutter, integration equals the full frame period between transfers.
// - Fast dump gate stays at its static disable level when dumping is unused.
package ccd_seq_pkg;

   // ***************************************************************
   // Clock and widths
   // ***************************************************************
   localparam int CLK_NS = 40;
   localparam int NS_PER_US = 1000;
   localparam int TCNT_W = 12;
   localparam int CNT_W = 10;
   localparam int DATA_W = 14;
   localparam int US_W = 16;

   // ***************************************************************
   // Timing figures and derived cycle counts
   // ***************************************************************
   localparam int SHUTTER_NS = 25000;
   localparam int INTEG_MIN_NS = 100000;
   localparam int XFER_NS = 5000;
   localparam int VPULSE_NS = 2500;
   localparam int AB_NS = 2500;
   localparam int RD_DELAY_NS = 10000;
   localparam int HDELAY_NS = 2500;
   localparam int VDELAY_NS = 25;
   localparam int ES_GAP_NS = 1000;

   localparam logic [TCNT_W-1:0] SHUTTER_CYC = TCNT_W'((SHUTTER_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TCNT_W-1:0] XFER_CYC = TCNT_W'((XFER_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TCNT_W-1:0] VPULSE_CYC = TCNT_W'((VPULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TCNT_W-1:0] AB_CYC = TCNT_W'((AB_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TCNT_W-1:0] RD_DELAY_CYC = TCNT_W'((RD_DELAY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TCNT_W-1:0] HDELAY_CYC = TCNT_W'((HDELAY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TCNT_W-1:0] VDELAY_CYC = TCNT_W'((VDELAY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TCNT_W-1:0] ES_GAP_CYC = TCNT_W'((ES_GAP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [4:0] US_CYC = 5'(NS_PER_US / CLK_NS);
   localparam logic [US_W-1:0] INTEG_MIN_US = US_W'(INTEG_MIN_NS / NS_PER_US);
   localparam logic [US_W-1:0] INTEG_MIN_CYC = US_W'(INTEG_MIN_NS / CLK_NS);

   // ***************************************************************
   // Pixel phases and static levels
   // ***************************************************************
   localparam logic [1:0] PH_RESET = 2'h0;
   localparam logic [1:0] PH_CLAMP = 2'h1;
   localparam logic [1:0] PH_SHIFT = 2'h2;
   localparam logic [1:0] PH_SAMPLE = 2'h3;
   localparam logic FDG_DISABLE = 1'b0;

   localparam logic [CNT_W-1:0] LINES_DEF = 10'h1f4;
   localparam logic [CNT_W-1:0] PIXELS_DEF = 10'h2bc;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,
      ST_ES_GAP  = 4'h1,
      ST_SHUTTER = 4'h2,
      ST_INTEG   = 4'h3,
      ST_XFER    = 4'h4,
      ST_RDELAY  = 4'h5,
      ST_V1      = 4'h6,
      ST_V2      = 4'h7,
      ST_AB      = 4'h8,
      ST_HDELAY  = 4'h9,
      ST_PIXEL   = 4'ha,
      ST_VDELAY  = 4'hb
   } state_t;

endpackage

// *** design/pix_skid_buf.sv ***
`timescale 1ns/10ps
module pix_skid_buf (
   input  wire logic                        clk_i,
   input  wire logic                        rstn_i,
   input  wire logic                        in_valid_i,
   input  wire logic [ccd_seq_pkg::DATA_W:0] in_data_i,
   output logic                             in_ready_o,
   output logic                             out_valid_o,
   output logic      [ccd_seq_pkg::DATA_W:0] out_data_o,
   input  wire logic                        out_ready_i
);
   import ccd_seq_pkg::*;

   logic              skid_v_q;
   logic [DATA_W:0]   skid_q;
   logic              push;
   logic              pop;

   // Ready comes from the skid flag so the source never sees a combinational path.
   assign in_ready_o = !skid_v_q;
   assign push = in_valid_i && !skid_v_q;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
         skid_v_q <= 1'b0;
         skid_q <= '0;
      end else if (pop) begin
         if (skid_v_q) begin
            out_data_o <= skid_q;
            skid_v_q <= 1'b0;
         end else begin
            out_valid_o <= push;
            out_data_o <= in_data_i;
         end
      end else if (push) begin
         if (!out_valid_o) begin
            out_valid_o <= 1'b1;
            out_data_o <= in_data_i;
         end else begin
            skid_v_q <= 1'b1;
            skid_q <= in_data_i;
         end
      end
   end

endmodule

// *** bench/ccd_sensor_model.sv ***
`timescale 1ns/10ps
// ********************
// Sensor pin model
// ********************
module ccd_sensor_model (
   input  wire logic        clk_i,
   input  wire logic        v1_i,
   input  wire logic        v2_i,
   input  wire logic        xfer_i,
   input  wire logic        h1a_i,
   input  wire logic        h1b_i,
   input  wire logic        h2_i,
   input  wire logic        ab_i,
   input  wire logic        rg_i,
   input  wire logic        clamp_i,
   input  wire logic        sample_i,
   input  wire logic        shut_i,
   input  wire logic        fdg_i,
   output logic [13:0]      adc_o,
   output logic             antiblm_on_o
);
   int unsigned shut_c, xfer_c, v1_c, v2_c, ab_c, ph, since_x, since_xf;
   int unsigned since_h = 100000;
   int unsigned since_s = 100000;
   int unsigned shut_w, xfer_w, v_min, ab_min, rd_w, integ_w, frame_w, hgap;
   int unsigned h1b_n, fdg_n, ord_err, xfer_n, pix_n;
   logic        h1b_q = 1'b0;
   logic        first_v = 1'b0;

   function automatic void track(input logic lvl, inout int unsigned c, inout int unsigned mn);
      if (lvl) begin
         c++;
      end else if (c != 0) begin
         if (c < mn) mn = c;
         c = 0;
      end
   endfunction

   assign antiblm_on_o = !xfer_i;
   // Between lines the video shows the inverted count, so a capture outside a pixel is caught.
   assign adc_o = (ph == 0) ? ~pix_n[13:0] : pix_n[13:0];

   always @(posedge clk_i) begin
      since_h++;
      since_s++;
      since_x++;
      since_xf++;
      if (h1a_i || h2_i) since_h = 0;
      if (shut_i) begin
         if (shut_c == 0) hgap = since_h;
         shut_c++;
      end else if (shut_c != 0) begin
         shut_w = shut_c;
         shut_c = 0;
         since_s = 0;
      end
      if (xfer_i) begin
         if (xfer_c == 0) begin
            frame_w = since_x;
            integ_w = since_s;
            since_x = 0;
            xfer_n++;
            v_min = 100000;
            ab_min = 100000;
         end
         xfer_c++;
      end else if (xfer_c != 0) begin
         xfer_w = xfer_c;
         xfer_c = 0;
         since_xf = 0;
         first_v = 1'b1;
      end
      if (v1_i && first_v) begin
         rd_w = since_xf;
         first_v = 1'b0;
      end
      track(v1_i, v1_c, v_min);
      track(v2_i, v2_c, v_min);
      track(ab_i, ab_c, ab_min);
      if (h1b_i !== h1b_q) h1b_n++;
      h1b_q = h1b_i;
      if (fdg_i !== 1'b0) fdg_n++;
      if (v1_i) ph = 0;
      if (rg_i) begin
         if (ph == 1 || ph == 2) ord_err++;
         ph = 1;
         pix_n++;
      end else if (clamp_i) begin
         if (ph != 1) ord_err++;
         ph = 2;
      end else if (sample_i) begin
         if (ph < 2) ord_err++;
         ph = 3;
      end
   end
endmodule

// *** bench/ccd_readout_timing_sequencer_tb.sv ***
`timescale 1ns/10ps
module ccd_readout_timing_sequencer_tb;
   import ccd_seq_pkg::*;
   localparam logic [CNT_W-1:0] PIXELS = 10'h4;
   logic              clk = 1'b0;
   logic              rstn = 1'b0;
   logic              start = 1'b0;
   logic              run = 1'b0;
   logic              shut_en = 1'b0;
   logic              dual = 1'b0;
   logic              ready = 1'b1;
   logic [US_W-1:0]   integ = 16'h0064;
   logic [DATA_W-1:0] adc, pix_data;
   logic [DATA_W-1:0] exp_pix = 14'h1;
   logic [CNT_W-1:0]  pos = 10'h0;
   logic              v1, v2, xfer, h1a, h1b, h2, ab, rg, clamp, sample, shut, fdg, busy;
   logic              valid, last;
   int unsigned       failures, num_checks, n_pop;

   ccd_readout_seq #(.N_LINES(10'h2), .N_PIXELS(PIXELS)) ccd_readout_seq_inst (
      .clk_i(clk), .rstn_i(rstn), .start_i(start), .run_i(run), .shutter_en_i(shut_en),
      .dual_reg_i(dual), .integ_us_i(integ), .adc_data_i(adc), .pix_ready_i(ready),
      .vertical_phase_one_o(v1), .vertical_phase_two_o(v2), .pd_xfer_o(xfer),
      .horiz_reg_a_phase_one_o(h1a), .horiz_reg_b_phase_one_o(h1b),
      .horiz_phase_two_o(h2), .reg_ab_xfer_o(ab), .reset_gate_o(rg), .clamp_o(clamp),
      .sample_o(sample), .substrate_shutter_o(shut), .fast_line_dump_gate_o(fdg),
      .busy_o(busy), .pix_valid_o(valid), .pix_data_o(pix_data), .pix_last_o(last));

   ccd_sensor_model ccd_sensor_model_inst (
      .clk_i(clk), .v1_i(v1), .v2_i(v2), .xfer_i(xfer), .h1a_i(h1a), .h1b_i(h1b),
      .h2_i(h2), .ab_i(ab), .rg_i(rg), .clamp_i(clamp), .sample_i(sample),
      .shut_i(shut), .fdg_i(fdg), .adc_o(adc), .antiblm_on_o());

   // ********************
   // Compare and verdict
   // ********************
   task automatic check_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_min(input int unsigned got, input int unsigned lo, input string what);
      num_checks++;
      if (got < lo) begin
         failures++;
         $display("[FAIL] %0t %s is %0d, below %0d", $time, what, got, lo);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      forever #20 clk = ~clk;
   end

   // The watchdog allows some three times the length of all frames.
   initial begin
      #1200000;
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end

   always @(posedge clk) begin
      if (valid === 1'b1 && ready === 1'b1) begin
         check_eq(16'(pix_data), 16'(exp_pix), "pixel word");
         check_eq(16'(last), 16'(pos == PIXELS - 1), "last flag");
         exp_pix <= exp_pix + 14'h1;
         pos <= (pos == PIXELS - 1) ? 10'h0 : pos + 10'h1;
         n_pop++;
      end
   end

   // ********************
   // Scenarios
   // ********************
   task automatic do_frame(input logic sh, du, two, poke, stall, input logic [US_W-1:0] us);
      int unsigned n0;
      int          i;
      n0 = ccd_sensor_model_inst.xfer_n;
      @(posedge clk);
      shut_en <= sh;
      dual <= du;
      run <= two;
      integ <= us;
      start <= 1'b1;
      for (i = 0; i < 8 && busy !== 1'b1; i++) @(posedge clk);
      start <= 1'b0;
      if (poke) begin
         repeat (200) @(posedge clk);
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
      end
      if (stall) begin
         for (i = 0; i < 5000 && valid !== 1'b1; i++) @(posedge clk);
         ready <= 1'b0;
         repeat (40) @(posedge clk);
         check_eq(16'({sample, valid}), 16'h3, "stalled sample and valid");
         ready <= 1'b1;
      end
      if (two) begin
         for (i = 0; i < 20000 && ccd_sensor_model_inst.xfer_n < n0 + 2; i++) @(posedge clk);
         run <= 1'b0;
      end
      for (i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge clk);
      repeat (8) @(posedge clk);
      check_eq(16'(busy), 16'h0, "sequencer back to idle");
      check_eq(16'(ccd_sensor_model_inst.xfer_n - n0), two ? 16'h2 : 16'h1, "frames");
      check_eq(16'(ccd_sensor_model_inst.ord_err), 16'h0, "pixel event order");
      check_min(ccd_sensor_model_inst.xfer_w, 100, "transfer width");
      check_min(ccd_sensor_model_inst.v_min, 50, "vertical pulse width");
      check_min(ccd_sensor_model_inst.rd_w, 250, "readout delay");
      check_eq(16'(ccd_sensor_model_inst.fdg_n), 16'h0, "dump gate activity");
   endtask

   task automatic test_single();
      int unsigned b0, p0;
      b0 = ccd_sensor_model_inst.h1b_n;
      p0 = n_pop;
      do_frame(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0064);
      check_eq(16'(ccd_sensor_model_inst.h1b_n - b0), 16'h0, "register b toggles");
      check_eq(16'(n_pop - p0), 16'h8, "words per frame");
      $display("test single done");
   endtask

   task automatic test_two_frames();
      do_frame(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0064);
      check_min(ccd_sensor_model_inst.frame_w, 652, "frame period");
      $display("test two frames done");
   endtask

   task automatic test_dual_shutter();
      int unsigned b0, p0;
      b0 = ccd_sensor_model_inst.h1b_n;
      p0 = n_pop;
      do_frame(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0005);
      check_min(ccd_sensor_model_inst.shut_w, 250, "shutter width");
      check_min(ccd_sensor_model_inst.integ_w, 2500, "integration");
      check_min(ccd_sensor_model_inst.hgap, 26, "shutter gap");
      check_min(ccd_sensor_model_inst.ab_min, 50, "a to b width");
      check_min(ccd_sensor_model_inst.h1b_n - b0, 1, "register b toggles");
      check_eq(16'(n_pop - p0), 16'h10, "words in two frames");
      $display("test dual shutter done");
   endtask

   initial begin
      repeat (9) @(posedge clk);
      check_eq(16'({v1, v2, xfer, h1a, h1b, h2, ab, rg, clamp, sample, shut, fdg, busy, valid}),
               16'h0, "outputs in reset");
      @(posedge clk);
      rstn <= 1'b1;
      test_single();
      test_two_frames();
      test_dual_shutter();
      print_verdict();
   end
endmodule
